/* File: hdl/isx_exec.sv */
// Execution unit for decrement/increment-and-skip and OR of W with file.
// Assumes one instruction cycle per mclk_i edge with a valid strobe, data memory
// read data returned combinationally in the same cycle as the read address.
// Also assumes the core leaves one free cycle after an op that writes back to
// a file register: the data address bus is shared, and while the write is
// pending it carries the write address, not the next read address.
// Overview of operation
// - Decrement, write per d, skip if nonzero
// - Increment, write per d, skip if zero
// - Increment, write per d, skip if nonzero
// - OR W with file, set N and Z only
// - Access 0 plus extended set indexes low operands
`timescale 1ns/1ps
`default_nettype none
module isx_exec
  import isx_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic insn_valid_i,
  input wire isx_insn_s insn_i,
  input wire logic next_two_word_i,
  input wire logic ext_set_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [11:0] fsr2_i,
  input wire logic [7:0] mem_rdata_i,
  output isx_mem_s mem_o,
  output logic [7:0] w_o,
  output logic [4:0] status_o,
  output logic skip_o,
  output logic busy_o,
  output logic accepted_o
);

  // Architectural state held here: W and the status flags
  logic [7:0] w_q;
  logic [7:0] w_d;
  logic [4:0] status_q;
  logic [4:0] status_d;
  // Skip sequencer and its one-cycle skip pulse
  isx_state_e state_q;
  isx_state_e state_d;
  logic skip_q;
  logic skip_d;
  // Pending write-back to data memory
  isx_mem_s mem_q;
  isx_mem_s mem_d;
  // Effective address and opcode decode
  logic [11:0] addr;
  logic op_dec_nz;
  logic op_inc_z;
  logic op_inc_nz;
  logic op_or;
  logic op_skip_kind;
  logic is_op;
  // Datapath result and the skip decision for this cycle
  logic [7:0] result;
  logic skip_now;

  // Effective address: banked, access bank or indexed off fsr2_i
  isx_addr_gen u_addr (
    .file_i(insn_i.file),
    .use_bank_i(insn_i.use_bank),
    .ext_set_i(ext_set_i),
    .bank_select_register_i(bank_select_register_i),
    .fsr2_i(fsr2_i),
    .addr_o(addr),
    .indexed_o()
  );

  // Opcode decode; any other code is left for the rest of the core
  assign op_dec_nz = (insn_i.opc == OPC_DEC_SKIP_NZ);
  assign op_inc_z = (insn_i.opc == OPC_INC_SKIP_Z);
  assign op_inc_nz = (insn_i.opc == OPC_INC_SKIP_NZ);
  assign op_or = (insn_i.opc == OPC_OR_W_FILE);
  assign op_skip_kind = op_dec_nz || op_inc_z || op_inc_nz;

  // A word offered while flushing is the discarded one, so it is never taken
  assign is_op = insn_valid_i && (state_q == ST_RUN) && (op_skip_kind || op_or);

  // Result and skip decision; read data must be valid in the same cycle
  always_comb begin
    result = mem_rdata_i;
    skip_now = 1'b0;
    unique case (insn_i.opc)
      // 00h minus one wraps to FFh, which is nonzero and so skips
      OPC_DEC_SKIP_NZ: begin
        result = mem_rdata_i - 8'h01;
        skip_now = (result != 8'h00);
      end
      // FFh plus one wraps to 00h, the only value that skips
      OPC_INC_SKIP_Z: begin
        result = mem_rdata_i + 8'h01;
        skip_now = (result == 8'h00);
      end
      OPC_INC_SKIP_NZ: begin
        result = mem_rdata_i + 8'h01;
        skip_now = (result != 8'h00);
      end
      // Flags are taken from the same value that is written
      OPC_OR_W_FILE: begin
        result = w_q | mem_rdata_i;
      end
      default: begin
        result = mem_rdata_i;
      end
    endcase
    skip_now = skip_now && is_op;
  end

  // Working register: takes the result when the destination bit is 0
  always_comb begin
    w_d = w_q;
    if (is_op && !insn_i.dest_file) begin
      w_d = result;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      w_q <= W_RESET;
    end else begin
      w_q <= w_d;
    end
  end

  // Status: skip opcodes leave every flag alone, OR touches N and Z only
  always_comb begin
    status_d = status_q;
    if (is_op && op_or) begin
      status_d[FLAG_N_POS] = result[7];
      status_d[FLAG_Z_POS] = (result == 8'h00);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // Write-back is registered so the strobe is clean for a whole cycle.
  // The price is a one-cycle gap: an op issued while the write is pending
  // would see the write address on the shared bus.
  always_comb begin
    mem_d = '0;
    if (is_op && insn_i.dest_file) begin
      mem_d.wr = 1'b1;
      mem_d.addr = addr;
      mem_d.wdata = result;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mem_q <= '0;
    end else begin
      mem_q <= mem_d;
    end
  end

  // Skip sequencing: one flush cycle, a second for a two-word victim
  always_comb begin
    state_d = state_q;
    skip_d = 1'b0;
    unique case (state_q)
      ST_RUN: begin
        if (skip_now) begin
          state_d = ST_FLUSH;
          skip_d = 1'b1;
        end
      end
      // This cycle's word is the discarded one; it is never taken
      ST_FLUSH: begin
        state_d = next_two_word_i ? ST_FLUSH2 : ST_RUN;
      end
      // Second word of a two-word victim is dropped as well
      ST_FLUSH2: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_q <= ST_RUN;
      skip_q <= 1'b0;
    end else begin
      state_q <= state_d;
      skip_q <= skip_d;
    end
  end

  // Read is live this cycle; the write lands one cycle later from a flop
  always_comb begin
    mem_o = mem_q;
    if (is_op) begin
      mem_o.rd = 1'b1;
      // A pending write-back keeps its own address on the bus
      if (!mem_q.wr) begin
        mem_o.addr = addr;
      end
    end
  end

  // Data outputs come straight from flops
  assign w_o = w_q;
  assign status_o = status_q;
  assign skip_o = skip_q;
  // Fetched word is discarded while flushing
  assign busy_o = (state_q != ST_RUN);
  // Taken in the cycle it is offered; the core advances on this
  assign accepted_o = is_op;

endmodule
`default_nettype wire

/* File: hdl/isx_pkg.sv */
// Package for the inc/dec-skip and OR execution block: opcodes, flags, limits.
// Assumes an 8-bit core with 16-bit instruction words and a 12-bit data address.
package isx_pkg;

  localparam logic [5:0] OPC_DEC_SKIP_NZ = 6'h13; // 0100 11
  localparam logic [5:0] OPC_INC_SKIP_Z = 6'h0f;  // 0011 11
  localparam logic [5:0] OPC_INC_SKIP_NZ = 6'h12; // 0100 10
  localparam logic [5:0] OPC_OR_W_FILE = 6'h04;   // 0001 00

  // Indexed literal offset applies at or below this file operand
  localparam logic [7:0] IDX_OFFSET_LIMIT = 8'h5f;
  // Access bank split: low part is GPR bank 0, high part is SFR bank 15
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] SFR_BANK = 4'hf;

  localparam int FLAG_N_POS = 4;
  localparam int FLAG_Z_POS = 2;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [4:0] STATUS_RESET = 5'h00;

  // Instruction word with its decoded fields
  typedef struct packed {
    logic [5:0] opc;
    logic dest_file;
    logic use_bank;
    logic [7:0] file;
  } isx_insn_s;

  // Data memory request to the outside
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } isx_mem_s;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_FLUSH = 3'b010,
    ST_FLUSH2 = 3'b100
  } isx_state_e;

endpackage

/* File: hdl/isx_addr_gen.sv */
// Effective data address for a byte-oriented instruction.
// Assumes FSR2 and the bank select register are supplied by the core.
`timescale 1ns/1ps
`default_nettype none
module isx_addr_gen
  import isx_pkg::*;
(
  input wire logic [7:0] file_i,
  input wire logic use_bank_i,
  input wire logic ext_set_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [11:0] fsr2_i,
  output logic [11:0] addr_o,
  output logic indexed_o
);

  // Access bit 0 with extended set on: low operands index off FSR2
  always_comb begin
    indexed_o = !use_bank_i && ext_set_i && (file_i <= IDX_OFFSET_LIMIT);
    if (indexed_o) begin
      addr_o = fsr2_i + {4'h0, file_i};
    end else if (use_bank_i) begin
      addr_o = {bank_select_register_i, file_i};
    end else if (file_i < ACCESS_SPLIT) begin
      addr_o = {4'h0, file_i};
    end else begin
      addr_o = {SFR_BANK, file_i};
    end
  end

endmodule
`default_nettype wire

/* File: tb/isx_exec_monitor.sv */
// Checker for the isx_exec ports.
// Assumes the bind below reaches every isx_exec.
`timescale 1ns/1ps
`default_nettype none
module isx_exec_monitor
  import isx_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire isx_insn_s insn_i,
  input wire logic ext_set_i,
  input wire logic [11:0] fsr2_i,
  input wire logic [7:0] mem_rdata_i,
  input wire isx_mem_s mem_o,
  input wire logic [7:0] w_o,
  input wire logic [4:0] status_o,
  input wire logic skip_o,
  input wire logic busy_o,
  input wire logic accepted_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // Opcode counts only when taken; none of the four codes is zero
  wire logic [5:0] op = insn_i.opc & {6{accepted_o}};
  wire logic [7:0] r = mem_rdata_i;
  dec_skip_a: assert property (op == OPC_DEC_SKIP_NZ |=> skip_o == ($past(r) != 8'h01))
    else $error("dec skip");
  incz_skip_a: assert property (op == OPC_INC_SKIP_Z |=> skip_o == ($past(r) == 8'hff))
    else $error("incz skip");
  incnz_skip_a: assert property (op == OPC_INC_SKIP_NZ |=> skip_o == ($past(r) != 8'hff))
    else $error("incnz skip");
  or_res_a: assert property (op == OPC_OR_W_FILE && !insn_i.dest_file |=>
    w_o == ($past(w_o) | $past(r)) && status_o[4] == w_o[7] && status_o[2] == !w_o)
    else $error("or result");
  idx_addr_a: assert property (accepted_o && !mem_o.wr && ext_set_i && !insn_i.use_bank
    && insn_i.file <= IDX_OFFSET_LIMIT |-> mem_o.addr == fsr2_i + {4'h0, insn_i.file})
    else $error("index addr");
  skip_idle_a: assert property (skip_o |-> busy_o && !accepted_o) else $error("skip idle");
  skip_flags_a: assert property (op == OPC_DEC_SKIP_NZ || op == OPC_INC_SKIP_Z ||
    op == OPC_INC_SKIP_NZ |=> status_o == $past(status_o))
    else $error("skip flags");
  dest_write_a: assert property (accepted_o |=> mem_o.wr == $past(insn_i.dest_file))
    else $error("dest write");
endmodule
bind isx_exec isx_exec_monitor u_mon (.*);
`default_nettype wire

/* File: tb/isx_dmem.sv */
// Data memory model on the far side.
// Assumes reads are answered in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module isx_dmem
  import isx_pkg::*;
(
  input wire logic mclk_i,
  input wire isx_mem_s mem_i,
  output logic [7:0] rdata_o
);
  logic [7:0] m [4096];
  // Without a read the bus shows inverted data, so stale bytes never match
  assign rdata_o = mem_i.rd ? m[mem_i.addr] : ~m[mem_i.addr];
  always @(posedge mclk_i) if (mem_i.wr) m[mem_i.addr] <= mem_i.wdata;
endmodule
`default_nettype wire

/* File: tb/isx_exec_tb_top.sv */
// Bench for isx_exec with a data memory model.
// Assumes bank 2 for table rows and an index base that the tests move.
`timescale 1ns/1ps
`default_nettype none
module isx_exec_tb_top;
  import isx_pkg::*;
  logic mclk_i = 0, srst_i = 1, vld = 0, two = 0, ext = 0, sk, bsy, acc;
  isx_insn_s ins = '0;
  isx_mem_s mem;
  logic [7:0] rd, w;
  logic [4:0] st;
  logic [11:0] fsr = 12'h123;
  int n_mismatch = 0, check_count = 0;
  // Row: opcode, dest and file data, result, skip and status
  logic [28:0] tv [7] = '{{OPC_OR_W_FILE, 9'h000, 8'h00, 6'h04},
    {OPC_OR_W_FILE, 9'h091, 8'h91, 6'h10},
    {OPC_OR_W_FILE, 9'h113, 8'h93, 6'h10}, {OPC_DEC_SKIP_NZ, 9'h001, 8'h00, 6'h10},
    {OPC_DEC_SKIP_NZ, 9'h100, 8'hff, 6'h30}, {OPC_INC_SKIP_Z, 9'h1ff, 8'h00, 6'h30},
    {OPC_INC_SKIP_NZ, 9'h000, 8'h01, 6'h30}};
  isx_exec DUT (.mclk_i(mclk_i), .srst_i(srst_i), .insn_valid_i(vld), .insn_i(ins),
    .next_two_word_i(two), .ext_set_i(ext), .bank_select_register_i(4'h2),
    .fsr2_i(fsr), .mem_rdata_i(rd), .mem_o(mem), .w_o(w), .status_o(st),
    .skip_o(sk), .busy_o(bsy), .accepted_o(acc));
  isx_dmem u_mem (.mclk_i(mclk_i), .mem_i(mem), .rdata_o(rd));
  initial forever #12.5 mclk_i = ~mclk_i;
  task automatic chk(input string nm, input logic [15:0] s, e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One op; during a skip the same word is offered again and must be refused
  task automatic go(input isx_insn_s x, input logic t, es, ea);
    @(posedge mclk_i);
    ins <= x;
    vld <= 1'b1;
    two <= t;
    #1 chk("taken", acc, ea);
    chk("read", mem.rd, ea);
    @(posedge mclk_i);
    vld <= es;
    #1 chk("skip", sk, es);
    chk("flush", {bsy, acc}, {es, 1'b0});
    @(posedge mclk_i);
    vld <= 1'b0;
    #1 chk("flush2", bsy, es & t);
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    foreach (tv[i]) begin
      u_mem.m[{4'h2, 8'(i)}] = tv[i][21:14];
      go({tv[i][28:22], 1'b1, 8'(i)}, 1'b0, tv[i][5], 1'b1);
      chk("result", tv[i][22] ? u_mem.m[{4'h2, 8'(i)}] : w, tv[i][13:6]);
      chk("status", st, tv[i][4:0]);
    end
    // Mid-run reset with W and N set by the rows above
    srst_i <= 1'b1;
    @(posedge mclk_i);
    srst_i <= 1'b0;
    #1 chk("reset", {w, 3'h0, st}, 16'h0000);
    chk("reset idle", {sk, bsy, mem.wr, mem.rd}, 4'h0);
    // Low access bank without the extended set, then indexed at the limit,
    // then just above it in the upper access bank
    u_mem.m[12'h020] = 8'h01;
    u_mem.m[12'h182] = 8'h40;
    u_mem.m[12'hf60] = 8'h02;
    go({OPC_OR_W_FILE, 2'b00, 8'h20}, 1'b0, 1'b0, 1'b1);
    ext <= 1'b1;
    go({OPC_OR_W_FILE, 2'b00, 8'h5f}, 1'b0, 1'b0, 1'b1);
    go({OPC_OR_W_FILE, 2'b00, 8'h60}, 1'b0, 1'b0, 1'b1);
    chk("w", w, 8'h43);
    // Index base near the top of the space: the sum wraps to 12 bits
    fsr <= 12'hfd0;
    u_mem.m[12'h02f] = 8'h80;
    go({OPC_OR_W_FILE, 2'b00, 8'h5f}, 1'b0, 1'b0, 1'b1);
    chk("wrap", {w, 3'h0, st}, 16'hc310);
    u_mem.m[12'h220] = 8'hff;
    go({OPC_INC_SKIP_Z, 2'b11, 8'h20}, 1'b1, 1'b1, 1'b1);
    chk("skip flags", st, 5'h10);
    go({6'h00, 2'b00, 8'h20}, 1'b0, 1'b0, 1'b0);
    chk("stay", {u_mem.m[12'h220], w}, 16'h00c3);
    stop_test();
  end
  initial begin
    #20us;
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
